/* File: rtl/mcex_pkg.sv */
// package: opcode fields, flag layout and timing constants for the execution subset
package mcex_pkg;
    localparam int          INSTR_W        = 14;
    localparam int          DATA_W         = 8;
    localparam int          ADDR_W         = 7;
    localparam int          OSC_PER_INSTR  = 4;   // oscillator periods in one instr_period
    localparam logic [1:0]  PHASE_LAST     = 2'h3;
    // opcode classes, top bits of the word
    localparam logic [5:0]  OP_ADD_REG     = 6'h07;
    localparam logic [5:0]  OP_AND_REG     = 6'h05;
    localparam logic [6:0]  OP_ZERO_REG    = 7'h03;  // top seven bits, d bit set
    localparam logic [3:0]  OP_BIT_CLR     = 4'h4;
    localparam logic [3:0]  OP_BIT_SET     = 4'h5;
    localparam logic [3:0]  OP_SKIP_ZERO   = 4'h6;
    localparam logic [3:0]  OP_SKIP_ONE    = 4'h7;
    localparam logic [4:0]  OP_ADD_LIT     = 5'h1f;
    localparam logic [5:0]  OP_AND_LIT     = 6'h39;
    // flag positions in the flag word
    localparam int          FLAG_C         = 0;
    localparam int          FLAG_HALF      = 1;
    localparam int          FLAG_Z         = 2;
    localparam logic [7:0]  ACC_RESET      = 8'h00;
    localparam logic [2:0]  FLAGS_RESET    = 3'h0;

    // write request towards the data register file
    typedef struct packed {
        logic                en;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } mcex_wr_t;

    typedef enum logic [1:0] {
        MCEX_EXEC   = 2'b00,
        MCEX_SQUASH = 2'b01
    } mcex_state_t;
endpackage

/* File: rtl/mcex_core.sv */
// module: executes the add/and/bit/clear/skip subset of an 8-bit core
// How it works
// - add literal adds the 8-bit immediate into the accumulator and updates carry, half carry and zero.
// - and literal ands the immediate into the accumulator and changes only zero.
// - add register sums accumulator and file register and updates carry, half carry and zero.
// - destination bit zero sends a register result to the accumulator, one writes it back to the register.
// - and register ands accumulator with the register into the chosen destination, changing only zero.
// - bit clear forces the indexed bit of the addressed register to zero and leaves flags alone.
// - bit set forces the indexed bit to one and leaves flags alone.
// - skip if one squashes the next instruction into a no-op when the tested bit is one.
// - skip if zero squashes the next instruction into a no-op when the tested bit is zero.
// - zero register writes zero to the register and sets the zero flag.
// - each instruction period spans four clocks and a taken skip costs a second no-op period.
module mcex_core (
    input  wire logic                            ref_clk_i,
    input  wire logic                            rst_n_i,
    input  wire logic [mcex_pkg::INSTR_W-1:0]    instr_i,      // fetched word, held for the period
    input  wire logic [mcex_pkg::DATA_W-1:0]     reg_rdata_i,  // file register at instr_i address
    output logic      [mcex_pkg::ADDR_W-1:0]     reg_raddr_o,
    output mcex_pkg::mcex_wr_t                   reg_wr_o,
    output logic      [mcex_pkg::DATA_W-1:0]     acc_o,
    output logic      [2:0]                      flags_o,
    output logic                                 fetch_o,      // pulse: next word wanted
    output logic                                 squash_o
);
    import mcex_pkg::*;

    // ************************************************************
    // instruction period timing
    // ************************************************************
    logic [1:0]                  phase;
    mcex_state_t                 state;
    logic                        last_q;

    // free-running phase counter, one instr_period per wrap
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign last_q   = (phase == PHASE_LAST);
    assign fetch_o  = last_q;
    assign squash_o = (state == MCEX_SQUASH);

    // ************************************************************
    // decode and execute
    // ************************************************************
    logic [DATA_W-1:0]           lit;
    logic [ADDR_W-1:0]           faddr;
    logic [2:0]                  bidx;
    logic                        dest;
    logic [DATA_W:0]             sum;
    logic [4:0]                  low_sum;
    logic [DATA_W-1:0]           next_acc;
    logic [2:0]                  next_flags;
    mcex_wr_t                    next_wr;
    logic                        next_skip;
    logic                        tbit;

    assign lit         = instr_i[7:0];
    assign faddr       = instr_i[6:0];
    assign bidx        = instr_i[9:7];
    assign dest        = instr_i[7];
    assign reg_raddr_o = faddr;
    assign tbit        = reg_rdata_i[bidx];

    // one combinational view of what this slot would do
    always_comb begin
        next_acc   = acc_o;
        next_flags = flags_o;
        next_wr    = '0;
        next_skip  = 1'b0;
        sum        = '0;
        low_sum    = '0;
        if (instr_i[13:9] == OP_ADD_LIT) begin
            sum     = {1'b0, acc_o} + {1'b0, lit};
            low_sum = {1'b0, acc_o[3:0]} + {1'b0, lit[3:0]};
            next_acc              = sum[7:0];
            next_flags[FLAG_C]    = sum[8];
            next_flags[FLAG_HALF] = low_sum[4];
            next_flags[FLAG_Z]    = (sum[7:0] == 8'h00);
        end else if (instr_i[13:8] == OP_AND_LIT) begin
            next_acc           = acc_o & lit;
            next_flags[FLAG_Z] = ((acc_o & lit) == 8'h00);
        end else if (instr_i[13:8] == OP_ADD_REG) begin
            sum     = {1'b0, acc_o} + {1'b0, reg_rdata_i};
            low_sum = {1'b0, acc_o[3:0]} + {1'b0, reg_rdata_i[3:0]};
            next_flags[FLAG_C]    = sum[8];
            next_flags[FLAG_HALF] = low_sum[4];
            next_flags[FLAG_Z]    = (sum[7:0] == 8'h00);
            if (dest) begin
                next_wr = '{en: 1'b1, addr: faddr, data: sum[7:0]};
            end else begin
                next_acc = sum[7:0];
            end
        end else if (instr_i[13:8] == OP_AND_REG) begin
            next_flags[FLAG_Z] = ((acc_o & reg_rdata_i) == 8'h00);
            if (dest) begin
                next_wr = '{en: 1'b1, addr: faddr, data: acc_o & reg_rdata_i};
            end else begin
                next_acc = acc_o & reg_rdata_i;
            end
        end else if (instr_i[13:7] == OP_ZERO_REG) begin
            next_wr            = '{en: 1'b1, addr: faddr, data: 8'h00};
            next_flags[FLAG_Z] = 1'b1;
        end else if (instr_i[13:10] == OP_BIT_CLR) begin
            next_wr = '{en: 1'b1, addr: faddr, data: reg_rdata_i & ~(8'h01 << bidx)};
        end else if (instr_i[13:10] == OP_BIT_SET) begin
            next_wr = '{en: 1'b1, addr: faddr, data: reg_rdata_i | (8'h01 << bidx)};
        end else if (instr_i[13:10] == OP_SKIP_ONE) begin
            next_skip = tbit;
        end else if (instr_i[13:10] == OP_SKIP_ZERO) begin
            next_skip = ~tbit;
        end
    end

    // slot state: a taken skip turns the following period into a no-op
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= MCEX_EXEC;
        end else if (last_q) begin
            case (state)
                MCEX_EXEC:   state <= next_skip ? MCEX_SQUASH : MCEX_EXEC;
                MCEX_SQUASH: state <= MCEX_EXEC;
                default:     state <= MCEX_EXEC;
            endcase
        end
    end

    // architectural state commits on the last phase only; squashed slots do nothing
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_o   <= ACC_RESET;
            flags_o <= FLAGS_RESET;
        end else if (last_q && state == MCEX_EXEC) begin
            acc_o   <= next_acc;
            flags_o <= next_flags;
        end
    end

    // register write is a one-clock pulse after commit
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_wr_o <= '0;
        end else if (last_q && state == MCEX_EXEC) begin
            reg_wr_o <= next_wr;
        end else begin
            reg_wr_o <= '0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_phase_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        fetch_o |=> !fetch_o [*3] ##1 fetch_o) else $error("period not four clocks");
    chk_squash_nowr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (squash_o && last_q) |=> !reg_wr_o.en) else $error("write in squashed slot");
    chk_squash_acc: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (squash_o && last_q) |=> $stable(acc_o) && $stable(flags_o)) else $error("state changed in squash");
    chk_skip_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:10] == OP_SKIP_ONE && tbit) |=> squash_o [*4])
        else $error("skip if one not taken");
    chk_skip_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:10] == OP_SKIP_ZERO && tbit) |=> !squash_o)
        else $error("skip if zero wrongly taken");
    chk_zero_reg: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:7] == OP_ZERO_REG) |=> reg_wr_o.en && reg_wr_o.data == 8'h00
        && flags_o[FLAG_Z]) else $error("zero register wrong");
    chk_and_lit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:8] == OP_AND_LIT) |=> acc_o == ($past(acc_o) & $past(lit))
        && flags_o[1:0] == $past(flags_o[1:0])) else $error("and literal wrong");
    chk_add_lit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:9] == OP_ADD_LIT) |=>
        {flags_o[FLAG_C], acc_o} == {1'b0, $past(acc_o)} + {1'b0, $past(lit)}) else $error("add literal wrong");
    chk_bit_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:10] == OP_BIT_SET) |=> reg_wr_o.en
        && reg_wr_o.data[$past(bidx)] && $stable(flags_o)) else $error("bit set wrong");
    chk_reg_dest: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:8] == OP_ADD_REG && !dest) |=> !reg_wr_o.en)
        else $error("dest zero wrote register");
    chk_add_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:9] == OP_ADD_LIT) |=> flags_o[FLAG_Z] == (acc_o == 8'h00))
        else $error("add literal zero flag wrong");

    // register-operand results, judged one clock after the commit edge
    chk_add_reg: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:8] == OP_ADD_REG) |=>
        {flags_o[FLAG_C], ($past(dest) ? reg_wr_o.data : acc_o)} ==
        {1'b0, $past(acc_o)} + {1'b0, $past(reg_rdata_i)}) else $error("add register wrong");
    chk_and_reg: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:8] == OP_AND_REG) |=>
        ($past(dest) ? reg_wr_o.data : acc_o) == ($past(acc_o) & $past(reg_rdata_i))
        && flags_o[1:0] == $past(flags_o[1:0])) else $error("and register wrong");
    chk_dest_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:8] == OP_AND_REG && dest) |=> reg_wr_o.en
        && reg_wr_o.addr == $past(faddr) && acc_o == $past(acc_o)) else $error("dest one missed register");

    // bit clear and the taken skip-if-zero path
    chk_bit_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:10] == OP_BIT_CLR) |=> reg_wr_o.en
        && !reg_wr_o.data[$past(bidx)] && $stable(flags_o)) else $error("bit clear wrong");
    chk_skip_taken: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (last_q && !squash_o && instr_i[13:10] == OP_SKIP_ZERO && !tbit) |=> squash_o [*4])
        else $error("skip if zero not taken");

    // a stretched strobe would write the file twice
    chk_wr_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_o.en |=> !reg_wr_o.en) else $error("register write longer than one clock");

    // main scenarios
    cov_skip: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) squash_o && last_q);
    cov_skip_zero: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        last_q && !squash_o && instr_i[13:10] == OP_SKIP_ZERO && !tbit);
    cov_dest_reg: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        last_q && !squash_o && instr_i[13:8] == OP_AND_REG && dest);
    cov_wr: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) reg_wr_o.en);
    cov_carry: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) flags_o[FLAG_C]);
endmodule

/* File: verif/mcex_regfile_model.sv */
// data register file model on the far side of the execution core
module mcex_regfile_model
    import mcex_pkg::*;
(
    input  wire logic                         ref_clk_i,
    input  wire mcex_pkg::mcex_wr_t           wr_i,
    input  wire logic [mcex_pkg::ADDR_W-1:0]  raddr_i,
    output logic      [mcex_pkg::DATA_W-1:0]  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [128];  // bench preloads cells directly

    // read is combinational, so the core sees the cell in the same clock
    assign rdata_o = mem[raddr_i];

    // one-clock write pulse lands at the next edge
    always @(posedge ref_clk_i) begin
        if (wr_i.en)
            mem[wr_i.addr] <= wr_i.data;
    end
endmodule

/* File: verif/mcex_core_test.sv */
// self-checking bench for the execution subset core
module mcex_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mcex_pkg::*;
    logic ref_clk_i, rst_n_i;
    logic [INSTR_W-1:0] instr_i;
    logic [DATA_W-1:0] reg_rdata_i, acc_o;
    logic [ADDR_W-1:0] reg_raddr_o;
    mcex_wr_t reg_wr_o;
    logic [2:0] flags_o;
    logic fetch_o, squash_o;
    int miscompares, samples_checked;

    mcex_core DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .reg_rdata_i(reg_rdata_i),
        .reg_raddr_o(reg_raddr_o), .reg_wr_o(reg_wr_o), .acc_o(acc_o), .flags_o(flags_o), .fetch_o(fetch_o),
        .squash_o(squash_o));
    mcex_regfile_model regs (.ref_clk_i(ref_clk_i), .wr_i(reg_wr_o), .raddr_i(reg_raddr_o), .rdata_o(reg_rdata_i));

    // ****
    // helpers
    // ****
    function automatic logic [13:0] lw(input logic a, input logic [7:0] k);
        return a ? {OP_ADD_LIT, 1'b0, k} : {OP_AND_LIT, k};
    endfunction
    function automatic logic [13:0] rw(input logic a, input logic d, input logic [6:0] f);
        return {(a ? OP_ADD_REG : OP_AND_REG), d, f};
    endfunction
    function automatic logic [13:0] bw(input logic [3:0] op, input logic [2:0] b, input logic [6:0] f);
        return {op, b, f};
    endfunction
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one full period: apply word at a falling edge, judge after the commit edge
    task automatic step(input logic [13:0] w, input logic sq, input logic [7:0] a, input logic [2:0] f,
                        input logic we, input logic [6:0] wa, input logic [7:0] wd);
        int n;
        n = 0;
        instr_i = w;
        cmp("squash", {7'h0, sq}, {7'h0, squash_o});
        while (fetch_o !== 1'b1 && n < 8) begin
            @(negedge ref_clk_i);
            n++;
        end
        cmp("period", 8'h3, n[7:0]);
        @(negedge ref_clk_i);
        cmp("acc", a, acc_o);
        cmp("flags", {5'h0, f}, {5'h0, flags_o});
        cmp("wr_en", {7'h0, we}, {7'h0, reg_wr_o.en});
        if (we) begin
            cmp("wr_addr", {1'b0, wa}, {1'b0, reg_wr_o.addr});
            cmp("wr_data", wd, reg_wr_o.data);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_literals();
        step(lw(0, 8'h00), 0, 8'h00, 3'h4, 0, 7'h00, 8'h00);
        step(lw(1, 8'hff), 0, 8'hff, 3'h0, 0, 7'h00, 8'h00);
        step(lw(1, 8'h81), 0, 8'h80, 3'h3, 0, 7'h00, 8'h00);
        step(lw(0, 8'h7f), 0, 8'h00, 3'h7, 0, 7'h00, 8'h00);
        step(lw(1, 8'h00), 0, 8'h00, 3'h4, 0, 7'h00, 8'h00);
        step({OP_ADD_LIT, 1'b1, 8'h0f}, 0, 8'h0f, 3'h0, 0, 7'h00, 8'h00);
        step(lw(0, 8'h00), 0, 8'h00, 3'h4, 0, 7'h00, 8'h00);
        step(14'h0000, 0, 8'h00, 3'h4, 0, 7'h00, 8'h00);
    endtask
    task automatic t_registers();
        regs.mem[7'h15] = 8'h0e;
        step(lw(1, 8'h02), 0, 8'h02, 3'h0, 0, 7'h00, 8'h00);
        step(rw(1, 1, 7'h15), 0, 8'h02, 3'h2, 1, 7'h15, 8'h10);
        step(rw(1, 0, 7'h15), 0, 8'h12, 3'h0, 0, 7'h00, 8'h00);
        step(lw(1, 8'hf0), 0, 8'h02, 3'h1, 0, 7'h00, 8'h00);
        step(rw(0, 0, 7'h15), 0, 8'h00, 3'h5, 0, 7'h00, 8'h00);
        step(rw(0, 1, 7'h15), 0, 8'h00, 3'h5, 1, 7'h15, 8'h00);
    endtask
    task automatic t_bits();
        regs.mem[7'h7f] = 8'h5a;
        step(lw(1, 8'h01), 0, 8'h01, 3'h0, 0, 7'h00, 8'h00);
        step(bw(OP_BIT_SET, 3'h0, 7'h7f), 0, 8'h01, 3'h0, 1, 7'h7f, 8'h5b);
        step(bw(OP_BIT_CLR, 3'h6, 7'h7f), 0, 8'h01, 3'h0, 1, 7'h7f, 8'h1b);
        step({OP_ZERO_REG, 7'h7f}, 0, 8'h01, 3'h4, 1, 7'h7f, 8'h00);
    endtask
    // taken skips must leave the next slot without any effect
    task automatic t_skips();
        regs.mem[7'h20] = 8'h01;
        step(bw(OP_SKIP_ONE, 3'h0, 7'h20), 0, 8'h01, 3'h4, 0, 7'h00, 8'h00);
        step(lw(1, 8'h10), 1, 8'h01, 3'h4, 0, 7'h00, 8'h00);
        step(bw(OP_SKIP_ZERO, 3'h0, 7'h20), 0, 8'h01, 3'h4, 0, 7'h00, 8'h00);
        step(lw(1, 8'h10), 0, 8'h11, 3'h0, 0, 7'h00, 8'h00);
        step(bw(OP_SKIP_ZERO, 3'h7, 7'h20), 0, 8'h11, 3'h0, 0, 7'h00, 8'h00);
        step({OP_ZERO_REG, 7'h20}, 1, 8'h11, 3'h0, 0, 7'h00, 8'h00);
        step(bw(OP_SKIP_ONE, 3'h1, 7'h20), 0, 8'h11, 3'h0, 0, 7'h00, 8'h00);
        step(bw(OP_BIT_SET, 3'h1, 7'h20), 0, 8'h11, 3'h0, 1, 7'h20, 8'h03);
    endtask
    // reset in mid-run: state clears at once and the next period is a full one
    task automatic t_reset();
        rst_n_i = 1'b0;
        @(negedge ref_clk_i);
        cmp("rst_acc", ACC_RESET, acc_o);
        cmp("rst_flags", {5'h0, FLAGS_RESET}, {5'h0, flags_o});
        cmp("rst_wr_en", 8'h00, {7'h0, reg_wr_o.en});
        cmp("rst_fetch", 8'h00, {7'h0, fetch_o});
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        step(lw(1, 8'h01), 0, 8'h01, 3'h0, 0, 7'h00, 8'h00);
    endtask

    // clock, 40 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // watchdog: the run needs about 130 clocks, allow far more
    initial begin
        #(40 * 3000);
        miscompares++;
        report_and_stop();
    end
    // main sequence, inputs change on falling edges only
    initial begin
        rst_n_i = 1'b0;
        instr_i = 14'h0000;
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        t_literals();
        t_registers();
        t_bits();
        t_skips();
        t_reset();
        report_and_stop();
    end
endmodule
